// ---- verilog/ttp_consts.svh ----
// named constants for the triple timer pwm unit
`ifndef TTP_CONSTS_SVH
`define TTP_CONSTS_SVH
`define TTP_CNT_W 16
`define TTP_CLK_HZ 25000000
`define TTP_SVC_LAST 2'h3
`define TTP_SVC_RST 2'h0
`define TTP_PIN_MODE_NORMAL 2'h0
`define TTP_PWD_W 16
`endif

// ---- verilog/ttp_pkg.sv ----
// types shared by the triple timer pwm unit
package ttp_pkg;
    // limit register that a timer is currently running against
    typedef enum logic {
        TTP_LIM_PRIMARY,
        TTP_LIM_SECONDARY
    } ttp_lim_t;
    // phase seen by the pulse width demodulator
    typedef enum logic [1:0] {
        TTP_PWD_IDLE,
        TTP_PWD_HIGH,
        TTP_PWD_LOW
    } ttp_pwd_st_t;
endpackage

// ---- verilog/ttp_tmr_if.sv ----
// carrier between the timer unit top and one timer core
`timescale 1ns/1ps
interface ttp_tmr_if #(parameter int W = 16);
    logic enable; // timer running enabled
    logic cont; // repeat after a period
    logic alt_en; // alternate primary and secondary limit
    logic cnt_evt; // qualified count event, only on service cycles
    logic [W-1:0] max_a; // primary limit
    logic [W-1:0] max_b; // secondary limit
    logic [W-1:0] count; // current count
    logic out; // waveform level
    logic done; // period complete pulse
    logic on_alt; // running against secondary limit
    modport ctl (output enable, cont, alt_en, cnt_evt, max_a, max_b, input count, out, done, on_alt);
    modport tmr (input enable, cont, alt_en, cnt_evt, max_a, max_b, output count, out, done, on_alt);
endinterface

// ---- verilog/ttp_timer.sv ----
// one 16-bit timer core with primary and optional secondary limit
`timescale 1ns/1ps
`include "ttp_consts.svh"
module ttp_timer #(
    parameter int W = `TTP_CNT_W,
    parameter bit HAS_ALT = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    ttp_tmr_if.tmr t
);
    logic [W-1:0] count_r, count_nxt; // the count itself
    logic out_r, out_nxt; // output waveform level
    logic done_r, done_nxt; // one-cycle period pulse
    logic run_r, run_nxt; // cleared after a single shot
    ttp_pkg::ttp_lim_t lim_r, lim_nxt; // limit in use
    logic [W-1:0] lim_val; // value of the limit in use
    logic alt_on; // alternation actually active

    // next state: advance only on a qualified event
    always_comb begin
        count_nxt = count_r;
        out_nxt = out_r;
        done_nxt = 1'b0;
        run_nxt = run_r;
        lim_nxt = lim_r;
        alt_on = HAS_ALT && t.alt_en;
        lim_val = (alt_on && lim_r == ttp_pkg::TTP_LIM_SECONDARY) ? t.max_b : t.max_a;
        if (!t.enable) begin
            // disabled: park at zero, armed, output idle high
            count_nxt = '0;
            out_nxt = 1'b1;
            run_nxt = 1'b1;
            lim_nxt = ttp_pkg::TTP_LIM_PRIMARY;
        end else if (t.cnt_evt && run_r) begin
            if (count_r == lim_val) begin
                count_nxt = '0;
                done_nxt = 1'b1;
                if (alt_on) begin
                    // high against primary, low against secondary
                    out_nxt = (lim_r == ttp_pkg::TTP_LIM_SECONDARY);
                    lim_nxt = (lim_r == ttp_pkg::TTP_LIM_PRIMARY) ? ttp_pkg::TTP_LIM_SECONDARY
                                                                   : ttp_pkg::TTP_LIM_PRIMARY;
                    if (!t.cont && lim_r == ttp_pkg::TTP_LIM_SECONDARY) begin
                        run_nxt = 1'b0;
                    end
                end else begin
                    // single limit: low for one count period, or held low once a single shot stops
                    out_nxt = 1'b0;
                    if (!t.cont) begin
                        run_nxt = 1'b0;
                    end
                end
            end else begin
                count_nxt = count_r + 1'b1;
                if (!alt_on) begin
                    out_nxt = 1'b1;
                end
            end
        end
    end

    // state registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            count_r <= '0;
            out_r <= 1'b1;
            done_r <= 1'b0;
            run_r <= 1'b1;
            lim_r <= ttp_pkg::TTP_LIM_PRIMARY;
        end else begin
            count_r <= count_nxt;
            out_r <= out_nxt;
            done_r <= done_nxt;
            run_r <= run_nxt;
            lim_r <= lim_nxt;
        end
    end

    assign t.count = count_r;
    assign t.out = out_r;
    assign t.done = done_r;
    assign t.on_alt = (lim_r == ttp_pkg::TTP_LIM_SECONDARY);
endmodule // ttp_timer

// ---- verilog/ttp_pwd.sv ----
// pulse width demodulator measuring high and low phases in service ticks
`timescale 1ns/1ps
`include "ttp_consts.svh"
module ttp_pwd #(
    parameter int W = `TTP_PWD_W
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic tick_i,
    input wire logic level_i,
    output logic [W-1:0] high_len_o,
    output logic [W-1:0] low_len_o,
    output logic high_vld_o,
    output logic low_vld_o
);
    ttp_pkg::ttp_pwd_st_t st_r, st_nxt; // phase being timed
    logic [W-1:0] run_r, run_nxt; // running phase length
    logic [W-1:0] hi_r, hi_nxt; // last high length
    logic [W-1:0] lo_r, lo_nxt; // last low length
    logic hv_r, hv_nxt; // high result pulse
    logic lv_r, lv_nxt; // low result pulse
    logic lvl_r, lvl_nxt; // input level one clock ago, used to find the first clean edge

    // next state: a phase ends at the opposite edge
    always_comb begin
        st_nxt = st_r;
        run_nxt = run_r;
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        hv_nxt = 1'b0;
        lv_nxt = 1'b0;
        lvl_nxt = level_i;
        case (st_r)
            ttp_pkg::TTP_PWD_IDLE: begin
                // first partial phase is thrown away, start at the next edge
                run_nxt = '0;
                // the phase under way at enable is partial, so timing waits for a real edge
                if (enable_i && level_i != lvl_r) begin
                    st_nxt = level_i ? ttp_pkg::TTP_PWD_HIGH : ttp_pkg::TTP_PWD_LOW;
                end
            end
            ttp_pkg::TTP_PWD_HIGH: begin
                if (!level_i) begin
                    hi_nxt = run_r;
                    hv_nxt = 1'b1;
                    run_nxt = '0;
                    st_nxt = ttp_pkg::TTP_PWD_LOW;
                end else if (tick_i && run_r != '1) begin
                    run_nxt = run_r + 1'b1; // saturates on very long phases
                end
            end
            ttp_pkg::TTP_PWD_LOW: begin
                if (level_i) begin
                    lo_nxt = run_r;
                    lv_nxt = 1'b1;
                    run_nxt = '0;
                    st_nxt = ttp_pkg::TTP_PWD_HIGH;
                end else if (tick_i && run_r != '1) begin
                    run_nxt = run_r + 1'b1;
                end
            end
            default: begin
                st_nxt = ttp_pkg::TTP_PWD_IDLE;
            end
        endcase
        if (!enable_i) begin
            st_nxt = ttp_pkg::TTP_PWD_IDLE;
        end
    end

    // state registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_r <= ttp_pkg::TTP_PWD_IDLE;
            run_r <= '0;
            hi_r <= '0;
            lo_r <= '0;
            hv_r <= 1'b0;
            lv_r <= 1'b0;
            lvl_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            run_r <= run_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            hv_r <= hv_nxt;
            lv_r <= lv_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign high_len_o = hi_r;
    assign low_len_o = lo_r;
    assign high_vld_o = hv_r;
    assign low_vld_o = lv_r;
endmodule // ttp_pwd

// ---- verilog/ttp_top.sv ----
// triple timer pwm unit: service divider, pin gating, event routing, three timers and demodulator
`timescale 1ns/1ps
`include "ttp_consts.svh"
// Operation
// - three independent timers, 16-bit counts each
// - first, second timers own in/out pins
// - third timer: time base, prescaler, DMA source
// - timers serviced once every fourth clock
// - output responds within six clocks
// - each timer has a primary limit
// - secondary limit alternates for duty cycle
// - external counting, one-shot or repeating waves
// - measure high and low phase widths
// - system clock undivided drives the unit
// - pin acts as timer only in mode 0
module ttp_top #(
    parameter int W = `TTP_CNT_W
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] tmr_en_i, // per timer enable
    input wire logic [2:0] tmr_cont_i, // per timer repeat
    input wire logic [2:0] tmr_int_en_i, // per timer completion flag enable
    input wire logic [1:0] tmr_alt_en_i, // pin timers: use secondary limit
    input wire logic [1:0] tmr_ext_clk_i, // pin timers: count input rising edges
    input wire logic [1:0] tmr_gate_en_i, // pin timers: input level gates ticks
    input wire logic [1:0] tmr_prescale_i, // pin timers: count third timer completions
    input wire logic dma_sel_i, // third timer completion requests dma
    input wire logic [3*W-1:0] tmr_max_a_i, // primary limits, timer 0 in low bits
    input wire logic [2*W-1:0] tmr_max_b_i, // secondary limits, pin timers
    input wire logic [1:0] first_timer_in_mode_i,
    input wire logic [1:0] first_timer_out_mode_i,
    input wire logic [1:0] second_timer_in_mode_i,
    input wire logic [1:0] second_timer_out_mode_i,
    input wire logic first_timer_in_pin_i,
    input wire logic second_timer_in_pin_i,
    input wire logic pulse_measure_input_i,
    input wire logic pwd_en_i, // pulse width demodulation on
    output logic first_timer_out_pin_o,
    output logic first_timer_out_pin_oe_o,
    output logic second_timer_out_pin_o,
    output logic second_timer_out_pin_oe_o,
    output logic [3*W-1:0] tmr_count_o, // live counts
    output logic [2:0] tmr_done_o, // completion pulses
    output logic dma_req_o, // dma request pulse
    output logic [`TTP_PWD_W-1:0] pwd_high_len_o,
    output logic [`TTP_PWD_W-1:0] pwd_low_len_o,
    output logic pwd_high_vld_o,
    output logic pwd_low_vld_o
);
    // service phase divider
    logic [1:0] svc_ph_r, svc_ph_nxt; // position within the four-clock service slot
    logic svc_tick; // one cycle in four

    // completion pulses and counts of all timers and pin timer levels, gathered for the shared logic
    logic [2:0] tifc_done_w;
    logic [3*W-1:0] tifc_count_w;
    logic [1:0] tifc_out_w;

    // per pin timer event routing
    logic [1:0] in_pin; // raw input pins
    logic [1:0] in_ok; // pin in timer function
    logic [1:0] out_ok; // output pin in timer function
    logic [1:0] in_prev_r, in_prev_nxt; // last sampled input level
    logic [1:0] pend_r, pend_nxt; // event waiting for the next service slot
    logic [1:0] src_evt; // raw edge or prescale event this cycle
    logic [1:0] gate_lvl; // gate level seen by the timer

    // registered top outputs
    logic [2:0] done_r, done_nxt; // flagged completion pulses
    logic dma_r, dma_nxt; // dma request pulse
    logic [1:0] oe_r, oe_nxt; // output pin drive enables

    ttp_tmr_if #(.W(W)) tifc[3] (); // one carrier per timer

    assign in_pin = {second_timer_in_pin_i, first_timer_in_pin_i};
    // the second timer input relies on an outside pull-up, so an open line reads high
    assign in_ok = {second_timer_in_mode_i == `TTP_PIN_MODE_NORMAL,
                    first_timer_in_mode_i == `TTP_PIN_MODE_NORMAL};
    assign out_ok = {second_timer_out_mode_i == `TTP_PIN_MODE_NORMAL,
                     first_timer_out_mode_i == `TTP_PIN_MODE_NORMAL};

    // next service phase: the core clock itself is the system clock, no division ahead
    always_comb begin
        svc_ph_nxt = svc_ph_r + 2'h1;
        svc_tick = (svc_ph_r == `TTP_SVC_LAST);
    end

    // service phase register
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            svc_ph_r <= `TTP_SVC_RST;
        end else begin
            svc_ph_r <= svc_ph_nxt;
        end
    end

    // pin timers: source selection, edge capture and pending events
    always_comb begin
        in_prev_nxt = in_prev_r;
        pend_nxt = pend_r;
        src_evt = 2'h0;
        gate_lvl = 2'h0;
        for (int i = 0; i < 2; i++) begin
            // a pin outside timer mode reads as a steady high gate and never edges
            gate_lvl[i] = in_ok[i] ? in_pin[i] : 1'b1;
            in_prev_nxt[i] = gate_lvl[i];
            if (tmr_prescale_i[i]) begin
                src_evt[i] = tifc_done_w[2];
            end else begin
                src_evt[i] = gate_lvl[i] & ~in_prev_r[i];
            end
            // edges between slots are held for the next service slot; several in one slot make a single event
            pend_nxt[i] = (pend_r[i] | src_evt[i]) & ~svc_tick & tmr_en_i[i];
        end
    end

    // pin timer event registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            in_prev_r <= 2'h3;
            pend_r <= 2'h0;
        end else begin
            in_prev_r <= in_prev_nxt;
            pend_r <= pend_nxt;
        end
    end

    // timers: drive carriers and instantiate the cores
    generate
        for (genvar g = 0; g < 3; g++) begin : g_tmr
            if (g < 2) begin : g_pin
                // pin timer: count edges, prescaled events, or gated service ticks
                always_comb begin
                    if (tmr_prescale_i[g] || tmr_ext_clk_i[g]) begin
                        tifc[g].cnt_evt = svc_tick & (pend_r[g] | src_evt[g]);
                    end else if (tmr_gate_en_i[g]) begin
                        tifc[g].cnt_evt = svc_tick & gate_lvl[g];
                    end else begin
                        tifc[g].cnt_evt = svc_tick;
                    end
                end
                assign tifc[g].alt_en = tmr_alt_en_i[g];
                assign tifc[g].max_b = tmr_max_b_i[g*W +: W];
                assign tifc_out_w[g] = tifc[g].out;
            end else begin : g_int
                // third timer has no pin and counts service ticks only
                assign tifc[g].cnt_evt = svc_tick;
                assign tifc[g].alt_en = 1'b0;
                assign tifc[g].max_b = '0;
            end
            assign tifc[g].enable = tmr_en_i[g];
            assign tifc[g].cont = tmr_cont_i[g];
            assign tifc[g].max_a = tmr_max_a_i[g*W +: W];
            assign tifc_done_w[g] = tifc[g].done;
            assign tifc_count_w[g*W +: W] = tifc[g].count;
            ttp_timer #(
                .W(W),
                .HAS_ALT(g < 2)
            ) u_tmr (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .t(tifc[g])
            );
        end
    endgenerate

    // completion flags, dma request and pin enables
    always_comb begin
        done_nxt = tifc_done_w & tmr_int_en_i;
        dma_nxt = tifc_done_w[2] & dma_sel_i & tmr_en_i[2];
        oe_nxt = out_ok & tmr_en_i[1:0];
    end

    // output registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            done_r <= 3'h0;
            dma_r <= 1'b0;
            oe_r <= 2'h0;
        end else begin
            done_r <= done_nxt;
            dma_r <= dma_nxt;
            oe_r <= oe_nxt;
        end
    end

    // pulse width demodulator on the interrupt input
    ttp_pwd #(
        .W(`TTP_PWD_W)
    ) u_pwd (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(pwd_en_i),
        .tick_i(svc_tick),
        .level_i(pulse_measure_input_i),
        .high_len_o(pwd_high_len_o),
        .low_len_o(pwd_low_len_o),
        .high_vld_o(pwd_high_vld_o),
        .low_vld_o(pwd_low_vld_o)
    );

    // timer waveform and count outputs come from the core flops
    assign first_timer_out_pin_o = tifc_out_w[0];
    assign second_timer_out_pin_o = tifc_out_w[1];
    assign first_timer_out_pin_oe_o = oe_r[0];
    assign second_timer_out_pin_oe_o = oe_r[1];
    assign tmr_count_o = tifc_count_w;
    assign tmr_done_o = done_r;
    assign dma_req_o = dma_r;

    // service slot repeats every four clocks
    a_svc_tick_period: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        svc_tick |=> !svc_tick [*3] ##1 svc_tick) else $error("service tick not one in four");

    // counts move only right after a service slot or on disable
    a_count_on_slot: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tmr_en_i[0] && $past(tmr_en_i[0]) && $changed(tifc_count_w[W-1:0]) |-> $past(svc_tick))
        else $error("first timer count moved outside a service slot");

    // a completion always leaves the count at zero
    a_wrap_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tifc_done_w[0] |-> tifc_count_w[W-1:0] == '0) else $error("first timer did not wrap to zero");

    // completion flag follows the core pulse only when enabled
    a_done_gated: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tifc_done_w[1] |=> tmr_done_o[1] == $past(tmr_int_en_i[1])) else $error("completion flag wrong");

    // a held edge or prescale event becomes a count event within the slot, never lost
    a_pend_served: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pend_r[0] && tmr_en_i[0] && !tmr_gate_en_i[0] |-> ##[0:3] tifc[0].cnt_evt)
        else $error("pending event not served in time");

    // output pin not driven unless in normal mode
    a_pin_mode_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        second_timer_out_mode_i != `TTP_PIN_MODE_NORMAL |=> !second_timer_out_pin_oe_o)
        else $error("second output driven outside normal mode");

    // dma request follows third timer completion by one clock
    a_dma_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tifc_done_w[2] && dma_sel_i && tmr_en_i[2] |=> dma_req_o) else $error("dma request missing");

    // in alternate mode the output is high while on the primary limit
    a_alt_level: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        tmr_en_i[1] && tmr_alt_en_i[1] && tifc_done_w[1] |-> second_timer_out_pin_o == !tifc[1].on_alt)
        else $error("alternate output level wrong");

    // a falling input while a high phase is timed reports it one clock later
    a_pwd_high: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pwd_en_i && u_pwd.st_r == ttp_pkg::TTP_PWD_HIGH && !pulse_measure_input_i |=> pwd_high_vld_o)
        else $error("high phase not reported");
endmodule // ttp_top

// ---- sim/ttp_ext_src.sv ----
// far-side model: event sources driving the timer and demodulator input pins
`timescale 1ns/1ps
module ttp_ext_src (
    input wire logic clk_i,
    output logic first_timer_in_pin_o,
    output logic second_timer_in_pin_o,
    output logic pulse_measure_input_o
);
    logic [2:0] lvl; // line levels; idle high, as the board pull-ups hold them
    assign first_timer_in_pin_o = lvl[0];
    assign second_timer_in_pin_o = lvl[1];
    assign pulse_measure_input_o = lvl[2];
    // all lines start released, so the pull-up level shows
    initial begin
        lvl = 3'h7;
    end
    // change one line just after a falling edge, away from the sampling edge
    task automatic drive(input int sel, input logic v);
        @(negedge clk_i);
        lvl[sel] = v;
    endtask
    // low phase, then a rising edge; the line is then left high like a released pull-up
    task automatic edge_up(input int sel, input int lo);
        drive(sel, 1'b0);
        repeat (lo) @(negedge clk_i);
        lvl[sel] = 1'b1;
    endtask
endmodule // ttp_ext_src

// ---- sim/triple_timer_pwm_unit_tb_top.sv ----
// self-checking testbench for the triple timer pwm unit
`timescale 1ns/1ps
module triple_timer_pwm_unit_tb_top;
    logic clk, rst_n, dma_sel, pwd_en; // clock, reset, single controls
    logic [2:0] en, cont, ie; // per timer controls
    logic [1:0] alt, ext, gate, pre, m0i, m0o, m1i, m1o; // pin timer controls and pin modes
    logic [47:0] max_a; // primary limits
    logic [31:0] max_b; // secondary limits
    wire p0i, p1i, pm; // lines from the far-side model
    logic o0, oe0, o1, oe1, dma, hv, lv; // single-bit results
    logic [47:0] cnt; // live counts
    logic [2:0] done; // completion pulses
    logic [15:0] hl, ll; // measured phase lengths
    int n_errors = 0;
    int comparisons = 0;
    ttp_ext_src u_src (.clk_i(clk), .first_timer_in_pin_o(p0i), .second_timer_in_pin_o(p1i),
        .pulse_measure_input_o(pm));
    ttp_top u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .tmr_en_i(en), .tmr_cont_i(cont), .tmr_int_en_i(ie),
        .tmr_alt_en_i(alt), .tmr_ext_clk_i(ext), .tmr_gate_en_i(gate), .tmr_prescale_i(pre),
        .dma_sel_i(dma_sel), .tmr_max_a_i(max_a), .tmr_max_b_i(max_b), .first_timer_in_mode_i(m0i),
        .first_timer_out_mode_i(m0o), .second_timer_in_mode_i(m1i), .second_timer_out_mode_i(m1o),
        .first_timer_in_pin_i(p0i), .second_timer_in_pin_i(p1i), .pulse_measure_input_i(pm),
        .pwd_en_i(pwd_en), .first_timer_out_pin_o(o0), .first_timer_out_pin_oe_o(oe0),
        .second_timer_out_pin_o(o1), .second_timer_out_pin_oe_o(oe1), .tmr_count_o(cnt),
        .tmr_done_o(done), .dma_req_o(dma), .pwd_high_len_o(hl), .pwd_low_len_o(ll),
        .pwd_high_vld_o(hv), .pwd_low_vld_o(lv));
    // 25 MHz clock
    initial clk = 1'b0;
    always #20 clk = ~clk;
    // exact comparison of one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded comparison, for latencies and lengths that the rules give as a limit
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        comparisons++;
        if (!(got >= lo && got <= hi)) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    // pick one watched output by number
    function automatic logic probe(input int k);
        case (k)
            0, 1, 2: return done[k];
            3: return dma;
            4: return o0;
            5: return o1;
            default: return hv;
        endcase
    endfunction
    // cycles until a watched output reaches a level, bounded so a stuck output cannot hang
    task automatic wait_lvl(input int k, input logic v, output int n);
        n = 0;
        while (probe(k) !== v && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask
    // distance between two successive pulses of a watched output
    task automatic period(input int k, output int p);
        int x;
        wait_lvl(k, 1'b1, x);
        @(negedge clk);
        wait_lvl(k, 1'b1, p);
        p++;
    endtask
    // everything off; inputs change only at the falling edge
    task automatic idle();
        {en, cont, ie, alt, ext, gate, pre, dma_sel, pwd_en} = '0;
        {m0i, m0o, m1i, m1o} = '0;
        max_a = '0;
        max_b = '0;
        repeat (3) @(negedge clk);
    endtask
    // reset state of the outputs
    task automatic t_reset();
        chk({o0, o1, oe0, oe1, done, dma}, 32'h0000_00c0);
        chk(cnt[31:0], 32'h0);
        $display("test reset done");
    endtask
    // each timer alone: wraps at its limit, one event every fourth clock
    task automatic t_period();
        int p;
        for (int i = 0; i < 3; i++) begin
            idle();
            max_a[16*i +: 16] = 16'h0003 + 16'(i);
            {en[i], cont[i], ie[i]} = 3'h7;
            period(i, p);
            chk(p, 4 * (4 + i));
            chk(cnt[16*i +: 16], 16'h0000);
        end
        $display("test period done");
    endtask
    // alternating limits give a programmable duty cycle
    task automatic t_alt();
        int n;
        idle();
        max_a[31:16] = 16'h0002;
        max_b[31:16] = 16'h0004;
        {en[1], cont[1], alt[1]} = 3'h7;
        wait_lvl(5, 1'b0, n);
        wait_lvl(5, 1'b1, n);
        wait_lvl(5, 1'b0, n);
        chk(n, 12);
        wait_lvl(5, 1'b1, n);
        chk(n, 20);
        chk(oe1, 1'b1);
        $display("test alternate done");
    endtask
    // external edges counted on both pin timers, output reacts quickly
    task automatic t_ext();
        int n;
        for (int i = 0; i < 2; i++) begin
            idle();
            max_a[16*i +: 16] = 16'h0002;
            {en[i], cont[i], ext[i], ie[i]} = 4'hf;
            repeat (2) begin
                u_src.edge_up(i, 4);
                repeat (8) @(negedge clk);
            end
            chk(cnt[16*i +: 16], 16'h0002);
            u_src.edge_up(i, 4);
            wait_lvl(4 + i, 1'b0, n);
            chk_rng(n, 0, 6);
            repeat (8) @(negedge clk);
            chk(cnt[16*i +: 16], 16'h0000);
        end
        $display("test external done");
    endtask
    // pins outside mode 0 lose their timer function
    task automatic t_mode();
        idle();
        {m1i, m1o} = 4'h5;
        max_a[31:16] = 16'h0002;
        {en[1], cont[1], ext[1]} = 3'h7;
        repeat (3) @(negedge clk);
        chk(oe1, 1'b0);
        repeat (2) u_src.edge_up(1, 4);
        repeat (8) @(negedge clk);
        chk(cnt[31:16], 16'h0000);
        $display("test mode done");
    endtask
    // gated counting: service ticks count only while the input pin is high
    task automatic t_gate();
        logic [15:0] c;
        idle();
        max_a[31:16] = 16'h00ff;
        {en[1], cont[1], gate[1]} = 3'h7;
        repeat (16) @(negedge clk);
        u_src.drive(1, 1'b0);
        c = cnt[31:16];
        repeat (16) @(negedge clk);
        chk(cnt[31:16], c);
        u_src.drive(1, 1'b1);
        repeat (16) @(negedge clk);
        chk(cnt[31:16], c + 16'h0004);
        $display("test gate done");
    endtask
    // third timer as prescaler and dma source
    task automatic t_prescale();
        int p;
        idle();
        max_a[47:32] = 16'h0001;
        max_a[15:0] = 16'h0001;
        {en[2], cont[2], ie[2], dma_sel} = 4'hf;
        {en[0], cont[0], ie[0], pre[0]} = 4'hf;
        period(3, p);
        chk(p, 8);
        period(0, p);
        chk(p, 16);
        $display("test prescale done");
    endtask
    // single shot: one completion, then it stays stopped
    task automatic t_single();
        int k;
        idle();
        max_a[15:0] = 16'h0001;
        {en[0], ie[0]} = 2'h3;
        k = 0;
        repeat (60) begin
            @(negedge clk);
            if (done[0] === 1'b1) k++;
        end
        chk(k, 1);
        chk(o0, 1'b0);
        $display("test single done");
    endtask
    // demodulator measures both phases in service ticks
    task automatic t_pwd();
        int n;
        idle();
        pwd_en = 1'b1;
        u_src.drive(2, 1'b0);
        repeat (8) @(negedge clk);
        u_src.drive(2, 1'b1);
        repeat (20) @(negedge clk);
        u_src.drive(2, 1'b0);
        wait_lvl(6, 1'b1, n);
        chk_rng(n, 1, 2);
        chk_rng(hl, 4, 6);
        repeat (23) @(negedge clk);
        u_src.drive(2, 1'b1);
        @(negedge clk);
        chk(lv, 1'b1);
        chk_rng(ll, 5, 7);
        $display("test demodulator done");
    endtask
    // counts and verdict, the one place the run ends
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        idle();
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_period();
        t_alt();
        t_ext();
        t_mode();
        t_gate();
        t_prescale();
        t_single();
        t_pwd();
        give_verdict();
    end
    // watchdog well past the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule // triple_timer_pwm_unit_tb_top
